/* src/pcd_pkg.sv */
// Package for the pulse capture timer and frequency divider block
package pcd_pkg;
    localparam int CNT_W = 8;
    localparam int PSC_W = 3;
    localparam int PSC_DIV_W = 7;
    // Mode select pair encodings
    localparam logic [1:0] MODE_NONE = 2'h0;
    localparam logic [1:0] MODE_EVENT = 2'h1;
    localparam logic [1:0] MODE_TIMER = 2'h2;
    localparam logic [1:0] MODE_CAPTURE = 2'h3;
    localparam logic [CNT_W-1:0] CNT_FULL = 8'hFF;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [PSC_DIV_W-1:0] PSC_ZERO = 7'h00;
    localparam logic [PSC_DIV_W-1:0] PSC_ONE = 7'h01;
    localparam logic [1:0] QUARTER_ZERO = 2'h0;
    localparam logic [1:0] QUARTER_LAST = 2'h3;
    localparam logic [1:0] PIN_SYNC_ZERO = 2'h0;

    // Timer control fields
    typedef struct packed {
        logic [1:0] mode_select_pair;
        logic clock_source;
        logic active_edge_select;
        logic [PSC_W-1:0] prescale_rate_bits;
    } pcd_ctrl_t;

    // Software accesses to one timer
    typedef struct packed {
        logic set_enable;
        logic clear_enable;
        logic preload_write;
        logic [CNT_W-1:0] preload_data;
        logic count_read;
    } pcd_sw_t;

    // Status returned to software for one timer
    typedef struct packed {
        logic count_enable_bit;
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] preload;
    } pcd_stat_t;
endpackage : pcd_pkg

/* src/pcd_timer_pfd.sv */
// Two capture timers with overflow-driven frequency divider outputs
// Operation
// - Mode pair 11 selects pulse width capture.
// - Capture counts selected internal clock after the prescaler.
// - Setting enable in capture waits for an active pin edge.
// - Edge select low: start on falling, stop on rising, clear enable.
// - Edge select high: start on rising, stop on falling, clear enable.
// - Hardware clears enable only in capture; other modes software only.
// - Counter holds measured value after capture ends.
// - After capture, pin ignored until software sets enable again.
// - Capture starts and stops on pin edges, not levels.
// - Overflow raises interrupt request, reloads preload, keeps counting.
// - Interrupt forwarded only while its enable bit is set.
// - Divider clock is timer 0 or timer 1 overflow per source bit.
// - Each selected overflow toggles both divider outputs.
// - Divider outputs held low while port data bit is zero.
// - Timer pin pull-high stays active while used as timer input.
// - Capture pin edges seen only at the next timer clock pulse; event mode counts edges at once.
// - Counter clock inhibited during counter read or preload write.
// - Mode pair: 00 none, 01 event, 10 timer, 11 capture.
// - Prescale codes divide by one up to 128 in powers of two.
// - Timer 1 source bit: zero sysclk/4, one low-freq crystal.
`timescale 1ns/1ps
module pcd_timer_pfd #(
    parameter int NUM_TIMERS = 2
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [NUM_TIMERS-1:0] i_timer_input_pin,
    input wire logic i_low_freq_crystal,
    input wire logic [NUM_TIMERS-1:0] i_pull_high_enable,
    input wire pcd_pkg::pcd_ctrl_t [NUM_TIMERS-1:0] i_ctrl,
    input wire pcd_pkg::pcd_sw_t [NUM_TIMERS-1:0] i_sw,
    input wire logic [NUM_TIMERS-1:0] i_int_enable,
    input wire logic i_int_flag_clear,
    input wire logic i_divider_source_select,
    input wire logic i_port_a_bit_one,
    output logic [NUM_TIMERS-1:0] o_pin_pull_high,
    output pcd_pkg::pcd_stat_t [NUM_TIMERS-1:0] o_stat,
    output logic [NUM_TIMERS-1:0] o_int_request,
    output logic [NUM_TIMERS-1:0] o_int_flag,
    output logic [1:0] o_divider_out
);
    import pcd_pkg::*;

    // ------------------------------------------------------------
    // Shared clock sources
    // ------------------------------------------------------------
    logic [1:0] quarter;
    logic [2:0] lxt_sync;
    logic lxt_level;
    logic lxt_tick;
    logic [NUM_TIMERS-1:0] overflow;

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            quarter <= QUARTER_ZERO;
        end else begin
            quarter <= quarter + 2'h1;
        end
    end

    // Crystal passes three flops, change accepted when last two agree
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            lxt_sync <= 3'h0;
            lxt_level <= 1'b0;
        end else begin
            lxt_sync <= {lxt_sync[1:0], i_low_freq_crystal};
            if (lxt_sync[1] == lxt_sync[2]) begin
                lxt_level <= lxt_sync[2];
            end
        end
    end
    assign lxt_tick = lxt_sync[1] && lxt_sync[2] && !lxt_level;

    function automatic logic src_tick(input int idx, input logic sel, input logic low_freq_crystal,
                                      input logic [1:0] q);
        if (sel) begin
            src_tick = low_freq_crystal;
        end else if (idx == 0) begin
            src_tick = 1'b1;
        end else begin
            src_tick = (q == QUARTER_LAST);
        end
    endfunction : src_tick

    // ------------------------------------------------------------
    // Timer channels
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_TIMERS; g++) begin : g_tmr
            logic [2:0] pin_sync;
            logic pin_level;
            logic pin_edge_rise;
            logic pin_edge_fall;
            logic rise_pend;
            logic fall_pend;
            logic [PSC_DIV_W-1:0] psc;
            logic [PSC_DIV_W-1:0] psc_mask;
            logic base_tick;
            logic tclk;
            logic inhibit;
            logic enable;
            logic capturing;
            logic [CNT_W-1:0] count;
            logic [CNT_W-1:0] preload;
            logic int_flag;
            logic int_req;
            logic [1:0] mode;
            logic start_edge;
            logic stop_edge;

            assign mode = i_ctrl[g].mode_select_pair;

            // Pin synchroniser and level filter
            always_ff @(posedge i_clock) begin
                if (i_rst) begin
                    pin_sync <= {1'b0, PIN_SYNC_ZERO};
                    pin_level <= 1'b0;
                end else begin
                    pin_sync <= {pin_sync[1:0], i_timer_input_pin[g]};
                    if (pin_sync[1] == pin_sync[2]) begin
                        pin_level <= pin_sync[2];
                    end
                end
            end
            assign pin_edge_rise = pin_sync[1] && pin_sync[2] && !pin_level;
            assign pin_edge_fall = !pin_sync[1] && !pin_sync[2] && pin_level;

            // Prescaler, powers of two
            assign base_tick = src_tick(g, i_ctrl[g].clock_source, lxt_tick, quarter);
            assign psc_mask = PSC_DIV_W'((8'h01 << i_ctrl[g].prescale_rate_bits) - 8'h01);
            assign inhibit = i_sw[g].count_read || i_sw[g].preload_write;
            assign tclk = base_tick && ((psc & psc_mask) == psc_mask) && !inhibit;

            always_ff @(posedge i_clock) begin
                if (i_rst) begin
                    psc <= PSC_ZERO;
                end else if (base_tick) begin
                    psc <= psc + PSC_ONE;
                end
            end

            // Edges held until next timer clock pulse
            always_ff @(posedge i_clock) begin
                if (i_rst || !enable) begin
                    rise_pend <= 1'b0;
                    fall_pend <= 1'b0;
                end else if (tclk) begin
                    rise_pend <= pin_edge_rise;
                    fall_pend <= pin_edge_fall;
                end else begin
                    rise_pend <= rise_pend || pin_edge_rise;
                    fall_pend <= fall_pend || pin_edge_fall;
                end
            end

            assign start_edge = i_ctrl[g].active_edge_select ? rise_pend : fall_pend;
            assign stop_edge = i_ctrl[g].active_edge_select ? fall_pend : rise_pend;

            // Enable bit and capture state
            always_ff @(posedge i_clock) begin
                if (i_rst) begin
                    enable <= 1'b0;
                    capturing <= 1'b0;
                end else if (i_sw[g].set_enable) begin
                    enable <= 1'b1;
                    capturing <= 1'b0;
                end else if (i_sw[g].clear_enable) begin
                    enable <= 1'b0;
                    capturing <= 1'b0;
                end else if (mode == MODE_CAPTURE && enable && tclk) begin
                    if (!capturing && start_edge) begin
                        capturing <= 1'b1;
                    end else if (capturing && stop_edge) begin
                        capturing <= 1'b0;
                        enable <= 1'b0;
                    end
                end else if (mode != MODE_CAPTURE) begin
                    capturing <= 1'b0;
                end
            end

            // Counter, preload and overflow
            logic count_step;
            always_comb begin
                unique case (mode)
                    MODE_TIMER: count_step = enable && tclk;
                    MODE_EVENT: begin
                        count_step = enable && !inhibit &&
                            (i_ctrl[g].active_edge_select ? pin_edge_fall : pin_edge_rise);
                    end
                    MODE_CAPTURE: count_step = enable && tclk && capturing && !stop_edge;
                    MODE_NONE: count_step = 1'b0;
                endcase
            end
            assign overflow[g] = count_step && (count == CNT_FULL);

            always_ff @(posedge i_clock) begin
                if (i_rst) begin
                    preload <= CNT_ZERO;
                end else if (i_sw[g].preload_write) begin
                    preload <= i_sw[g].preload_data;
                end
            end

            always_ff @(posedge i_clock) begin
                if (i_rst) begin
                    count <= CNT_ZERO;
                end else if (i_sw[g].preload_write && !enable) begin
                    count <= i_sw[g].preload_data;
                end else if (overflow[g]) begin
                    count <= preload;
                end else if (count_step) begin
                    count <= count + 8'h01;
                end
            end

            // Overflow flag, set wins over clear
            always_ff @(posedge i_clock) begin
                if (i_rst) begin
                    int_flag <= 1'b0;
                    int_req <= 1'b0;
                end else begin
                    int_flag <= overflow[g] || (int_flag && !i_int_flag_clear);
                    int_req <= i_int_enable[g] &&
                        (overflow[g] || (int_flag && !i_int_flag_clear));
                end
            end

            always_ff @(posedge i_clock) begin
                if (i_rst) begin
                    o_stat[g] <= '0;
                    o_pin_pull_high[g] <= 1'b0;
                end else begin
                    o_stat[g].count_enable_bit <= enable;
                    o_stat[g].count <= count;
                    o_stat[g].preload <= preload;
                    o_pin_pull_high[g] <= i_pull_high_enable[g];
                end
            end

            assign o_int_flag[g] = int_flag;
            assign o_int_request[g] = int_req;
        end
    endgenerate

    // ------------------------------------------------------------
    // Frequency divider
    // ------------------------------------------------------------
    logic pfd_state;
    logic pfd_ovf;
    assign pfd_ovf = i_divider_source_select ? overflow[NUM_TIMERS-1] : overflow[0];

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            pfd_state <= 1'b0;
        end else if (pfd_ovf) begin
            pfd_state <= !pfd_state;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst || !i_port_a_bit_one) begin
            o_divider_out <= 2'h0;
        end else if (pfd_ovf) begin
            o_divider_out <= {2{!pfd_state}};
        end else begin
            o_divider_out <= {2{pfd_state}};
        end
    end
endmodule : pcd_timer_pfd

/* testbench/pcd_timer_pfd_assertions.sv */
// Port checker for the capture timer and divider block
`timescale 1ns/1ps
module pcd_timer_pfd_assertions
    import pcd_pkg::*;
#(
    parameter int NUM_TIMERS = 2
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [NUM_TIMERS-1:0] i_pull_high_enable,
    input wire pcd_pkg::pcd_ctrl_t [NUM_TIMERS-1:0] i_ctrl,
    input wire pcd_pkg::pcd_sw_t [NUM_TIMERS-1:0] i_sw,
    input wire logic [NUM_TIMERS-1:0] i_int_enable,
    input wire logic i_divider_source_select,
    input wire logic i_port_a_bit_one,
    input wire logic [NUM_TIMERS-1:0] o_pin_pull_high,
    input wire pcd_pkg::pcd_stat_t [NUM_TIMERS-1:0] o_stat,
    input wire logic [NUM_TIMERS-1:0] o_int_request,
    input wire logic [NUM_TIMERS-1:0] o_int_flag,
    input wire logic [1:0] o_divider_out
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    sequence s_idle_two;
        !o_stat[0].count_enable_bit && !$past(o_stat[0].count_enable_bit)
            && !$past(i_sw[0].preload_write, 2);
    endsequence
    sequence s_reload;
        $past(o_stat[0].count) == CNT_FULL && o_stat[0].count == o_stat[0].preload;
    endsequence
    div_pair_equal_a: assert property (o_divider_out[0] == o_divider_out[1])
        else $error("divider outputs differ");
    div_port_off_a: assert property (!i_port_a_bit_one |=> o_divider_out == 2'h0)
        else $error("divider not low with port bit clear");
    int_mask_a: assert property (!i_int_enable[1] [*2] |-> !o_int_request[1])
        else $error("request while masked");
    pull_high_a: assert property (!$past(i_rst) |-> o_pin_pull_high == $past(i_pull_high_enable))
        else $error("pull-high not kept");
    set_enable_a: assert property (i_sw[0].set_enable |-> ##2 o_stat[0].count_enable_bit)
        else $error("enable not set");
    sw_clear_only_a: assert property ($fell(o_stat[1].count_enable_bit)
        && i_ctrl[1].mode_select_pair != MODE_CAPTURE |-> $past(i_sw[1].clear_enable, 2))
        else $error("enable cleared outside capture");
    capture_hold_a: assert property (s_idle_two |-> $stable(o_stat[0].count))
        else $error("count moved while disabled");
    overflow_flag_a: assert property (s_reload |-> ##[0:2] o_int_flag[0])
        else $error("overflow flag missing");
    div_toggle_a: assert property ($rose(o_int_flag[0]) && !i_divider_source_select
        && i_port_a_bit_one && $past(i_port_a_bit_one, 2) |-> ##[0:1] $changed(o_divider_out))
        else $error("divider did not toggle");
endmodule : pcd_timer_pfd_assertions

bind pcd_timer_pfd pcd_timer_pfd_assertions #(.NUM_TIMERS(NUM_TIMERS)) u_chk (.*);

/* testbench/pcd_pulse_src.sv */
// Model of the external pulse sources and the divider load
`timescale 1ns/1ps
module pcd_pulse_src (
    input wire logic i_clock,
    input wire logic [1:0] i_go,
    input wire logic [1:0] i_idle_high,
    input wire logic [7:0] i_width,
    input wire logic [1:0] i_divider_out,
    output logic [1:0] o_pin,
    output logic [7:0] o_load_edges
);
    logic [7:0] left [2];
    logic [1:0] last_div;
    initial begin
        left[0] = 8'h00;
        left[1] = 8'h00;
        last_div = 2'h0;
        o_load_edges = 8'h00;
    end
    always @(posedge i_clock) begin
        for (int t = 0; t < 2; t++) begin
            if (i_go[t]) left[t] <= i_width;
            else if (left[t] != 8'h00) left[t] <= left[t] - 8'h01;
        end
        last_div <= i_divider_out;
        if (i_divider_out != last_div) o_load_edges <= o_load_edges + 8'h01;
    end
    // Pin rests at its i_idle_high level between pulses
    assign o_pin[0] = i_idle_high[0] ^ (left[0] != 8'h00);
    assign o_pin[1] = i_idle_high[1] ^ (left[1] != 8'h00);
endmodule : pcd_pulse_src

/* testbench/pcd_timer_pfd_tb.sv */
// Self-checking bench for the capture timer and divider block
`timescale 1ns/1ps
module pcd_timer_pfd_tb;
    import pcd_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic lfx = 1'b0;
    logic iclr = 1'b0;
    logic dsel = 1'b0;
    logic pa1 = 1'b0;
    logic [1:0] go = 2'h0;
    logic [1:0] idle_hi = 2'h1;
    logic [1:0] pull = 2'h0;
    logic [1:0] int_en = 2'h0;
    logic [1:0] pin, ph, ireq, iflag, dout;
    logic [7:0] width = 8'h00;
    logic [7:0] edges, e0;
    pcd_ctrl_t [1:0] ctrl = '0;
    pcd_sw_t [1:0] sw = '0;
    pcd_stat_t [1:0] stat;
    int fails = 0;
    int n_tests = 0;
    always #12.5 clk = ~clk;
    pcd_pulse_src src (.i_clock(clk), .i_go(go), .i_idle_high(idle_hi), .i_width(width),
        .i_divider_out(dout), .o_pin(pin), .o_load_edges(edges));
    pcd_timer_pfd #(.NUM_TIMERS(2)) uut (.i_clock(clk), .i_rst(rst), .i_timer_input_pin(pin),
        .i_low_freq_crystal(lfx), .i_pull_high_enable(pull), .i_ctrl(ctrl), .i_sw(sw),
        .i_int_enable(int_en), .i_int_flag_clear(iclr), .i_divider_source_select(dsel),
        .i_port_a_bit_one(pa1), .o_pin_pull_high(ph), .o_stat(stat), .o_int_request(ireq),
        .o_int_flag(iflag), .o_divider_out(dout));
    // --------------------------------
    // Access and check tasks
    // --------------------------------
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    function automatic logic [7:0] near(input logic [7:0] c, input logic [7:0] e);
        return {7'h00, (c >= e - 8'd2) && (c <= e + 8'd2)};
    endfunction : near
    task automatic swp(input int t, input pcd_sw_t v);
        @(posedge clk) sw[t] <= v;
        @(posedge clk) sw[t] <= '0;
    endtask : swp
    task automatic capture(input int t, input logic [7:0] w, input logic [7:0] p);
        int k;
        swp(t, 12'h800);
        repeat (8) @(posedge clk);
        chk("armed_en", stat[t].count_enable_bit, 8'h01);
        chk("armed_cnt", stat[t].count, p);
        @(posedge clk) begin
            width <= w;
            go[t] <= 1'b1;
        end
        @(posedge clk) go[t] <= 1'b0;
        k = 0;
        while (stat[t].count_enable_bit !== 1'b0 && k < 500) begin
            @(posedge clk);
            k++;
        end
        chk("auto_clear", stat[t].count_enable_bit, 8'h00);
        swp(t, 12'h001);
        repeat (2) @(posedge clk);
    endtask : capture
    task automatic finish_test;
        $display("Checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finish_test
    initial begin
        repeat (4000) @(posedge clk);
        fails++;
        finish_test();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk) begin
            ctrl[0] <= {MODE_CAPTURE, 1'b0, 1'b0, 3'h1};
            ctrl[1] <= {MODE_CAPTURE, 1'b0, 1'b1, 3'h0};
            pull <= 2'h3;
        end
        swp(0, 12'h200);
        capture(0, 8'd40, 8'h00);
        chk("cap_fall", near(stat[0].count, 8'd20), 8'h01);
        chk("pull_high", ph, 8'h03);
        e0 = stat[0].count;
        @(posedge clk) go[0] <= 1'b1;
        @(posedge clk) go[0] <= 1'b0;
        repeat (60) @(posedge clk);
        chk("rearm", stat[0].count, e0);
        $display("Test falling capture done");
        swp(1, 12'h200);
        capture(1, 8'd40, 8'h00);
        chk("cap_rise", near(stat[1].count, 8'd10), 8'h01);
        $display("Test rising capture done");
        @(posedge clk) begin
            ctrl[0] <= {MODE_CAPTURE, 1'b0, 1'b0, 3'h0};
            int_en <= 2'h1;
            pa1 <= 1'b1;
        end
        swp(0, 12'h3E0);
        capture(0, 8'd26, 8'hF0);
        chk("ovf_count", near(stat[0].count, 8'hFA), 8'h01);
        chk("ovf_flag", {iflag[0], ireq[0]}, 8'h03);
        chk("div_out", dout, 8'h03);
        chk("div_edges", edges, 8'h01);
        @(posedge clk) begin
            iclr <= 1'b1;
            pa1 <= 1'b0;
        end
        @(posedge clk) iclr <= 1'b0;
        repeat (3) @(posedge clk);
        chk("flag_clear", iflag, 8'h00);
        chk("div_off", dout, 8'h00);
        $display("Test overflow done");
        @(posedge clk) begin
            ctrl[1] <= {MODE_TIMER, 1'b0, 1'b0, 3'h0};
            pa1 <= 1'b1;
        end
        swp(1, 12'h3FC);
        swp(1, 12'h800);
        repeat (3) @(posedge clk);
        e0 = edges;
        repeat (40) @(posedge clk);
        chk("mask_req", {iflag[1], ireq[1]}, 8'h02);
        chk("div_src0", edges, e0);
        chk("sw_only", stat[1].count_enable_bit, 8'h01);
        @(posedge clk) dsel <= 1'b1;
        repeat (20) @(posedge clk);
        chk("div_src1", {7'h00, edges != e0}, 8'h01);
        swp(1, 12'h400);
        repeat (2) @(posedge clk);
        chk("sw_clear", stat[1].count_enable_bit, 8'h00);
        $display("Test timer mode done");
        swp(1, 12'h220);
        @(posedge clk) ctrl[1] <= {MODE_TIMER, 1'b1, 1'b0, 3'h0};
        swp(1, 12'h800);
        repeat (5) begin
            repeat (4) @(posedge clk) lfx <= 1'b1;
            repeat (4) @(posedge clk) lfx <= 1'b0;
        end
        repeat (6) @(posedge clk);
        chk("lxt_count", stat[1].count, 8'h15);
        swp(1, 12'h400);
        $display("Test crystal source done");
        swp(0, 12'h200);
        @(posedge clk) ctrl[0] <= {MODE_EVENT, 1'b0, 1'b0, 3'h0};
        swp(0, 12'h800);
        repeat (8) @(posedge clk);
        @(posedge clk) begin
            width <= 8'd4;
            go[0] <= 1'b1;
        end
        @(posedge clk) go[0] <= 1'b0;
        repeat (20) @(posedge clk);
        chk("event_cnt", stat[0].count, 8'h01);
        chk("event_en", stat[0].count_enable_bit, 8'h01);
        $display("Test event mode done");
        finish_test();
    end
endmodule : pcd_timer_pfd_tb
